// ==== logic/i2c_status_consts.svh ====
`ifndef I2C_STATUS_CONSTS_SVH
`define I2C_STATUS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define MCON_ADDR 32'h4000_3400
`define MSTAT_ADDR 32'h4000_3404
`define MRX_ADDR 32'h4000_3408
`define MTX_ADDR 32'h4000_340C

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define MCON_RESET 16'h0000
`define MCON_WMASK 16'h0DFF
`define MSTAT_RESET 16'h6000
`define ZERO16 16'h0000
`define ZERO8 8'h00

// ----------------------------------------------------------------------
// Master control bit positions
// ----------------------------------------------------------------------
`define MCON_MASTER_EN 0
`define MCON_RXREQ_IEN 4
`define MCON_TXREQ_IEN 5
`define MCON_ARB_IEN 6
`define MCON_NACK_IEN 7
`define MCON_CMP_IEN 8

// ----------------------------------------------------------------------
// Master status bit positions
// ----------------------------------------------------------------------
`define ST_FILL_LO 0
`define ST_FILL_HI 1
`define ST_TXREQ 2
`define ST_RXREQ 3
`define ST_ADDR_NACK 4
`define ST_ARB_LOST 5
`define ST_MASTER_BUSY 6
`define ST_DATA_NACK 7
`define ST_TRANSACTION_COMPLETE_FLAG 8
`define ST_RX_OVF 9
`define ST_LINE_BUSY 10
`define ST_OWN_STOP 11
`define ST_TX_UFLOW 12
`define ST_SDA 13
`define ST_SCL 14

// ----------------------------------------------------------------------
// Transmit fill codes and line filter length
// ----------------------------------------------------------------------
`define FILL_CODE_EMPTY 2'h0
`define FILL_CODE_ONE 2'h2
`define FILL_CODE_FULL 2'h3
`define GLITCH_SAMPLES 3

`endif

// ==== logic/i2c_status_pkg.sv ====
package i2c_status_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;

  // Occupancy of a two-byte master FIFO
  typedef enum logic [1:0] {
    FILL_EMPTY,
    FILL_ONE,
    FILL_FULL
  } fill_e;

endpackage : i2c_status_pkg

// ==== logic/line_if.sv ====
`timescale 1ns/1ns
`default_nettype none

// Link-domain line state handed to the core domain
interface line_if;
  logic scl_filt;
  logic sda_filt;
  logic start_tgl;
  logic stop_tgl;

  modport mon (output scl_filt, output sda_filt, output start_tgl, output stop_tgl);
  modport core (input scl_filt, input sda_filt, input start_tgl, input stop_tgl);
endinterface : line_if

`default_nettype wire

// ==== logic/line_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "i2c_status_consts.svh"

module line_monitor
  import i2c_status_pkg::*;
#(
  parameter int FILT_LEN = `GLITCH_SAMPLES
) (
  // Link clock and reset
  input wire logic i_link_clk,
  input wire logic i_resetn,
  // Bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // Core side
  line_if.mon lines
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
    end
  end

  // --------------------------------------------------------------------
  // Glitch filter: a level is taken once it holds for FILT_LEN samples
  // --------------------------------------------------------------------
  logic [FILT_LEN-1:0] scl_hist_q;
  logic [FILT_LEN-1:0] sda_hist_q;
  logic scl_filt_q;
  logic sda_filt_q;

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_hist_q <= '1;
      sda_hist_q <= '1;
    end else begin
      scl_hist_q <= {scl_hist_q[FILT_LEN-2:0], scl_sync_q[1]};
      sda_hist_q <= {sda_hist_q[FILT_LEN-2:0], sda_sync_q[1]};
    end
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_filt_q <= 1'b1;
      sda_filt_q <= 1'b1;
    end else begin
      if (&scl_hist_q) scl_filt_q <= 1'b1;
      else if (~|scl_hist_q) scl_filt_q <= 1'b0;
      if (&sda_hist_q) sda_filt_q <= 1'b1;
      else if (~|sda_hist_q) sda_filt_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Start and stop detection, sent across as toggles
  // --------------------------------------------------------------------
  logic sda_prev_q;
  logic start_tgl_q;
  logic stop_tgl_q;

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sda_prev_q <= 1'b1;
      start_tgl_q <= 1'b0;
      stop_tgl_q <= 1'b0;
    end else begin
      sda_prev_q <= sda_filt_q;
      // Data falls while the clock is high
      if (scl_filt_q && sda_prev_q && !sda_filt_q) start_tgl_q <= ~start_tgl_q;
      // Data rises while the clock is high
      if (scl_filt_q && !sda_prev_q && sda_filt_q) stop_tgl_q <= ~stop_tgl_q;
    end
  end

  assign lines.scl_filt = scl_filt_q;
  assign lines.sda_filt = sda_filt_q;
  assign lines.start_tgl = start_tgl_q;
  assign lines.stop_tgl = stop_tgl_q;

endmodule : line_monitor

`default_nettype wire

// ==== logic/i2c_master_status.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_status_consts.svh"

module i2c_master_status
  import i2c_status_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int FIFO_DEPTH = 2
) (
  // Clocks and reset
  input wire logic i_core_clk,
  input wire logic i_link_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // Master state machine events and state
  input wire logic i_machine_busy,
  input wire logic i_direction_read,
  input wire logic i_own_stop,
  input wire logic i_tx_empty_end,
  input wire logic i_data_nack,
  input wire logic i_addr_nack,
  input wire logic i_arb_lost,
  // Transmit FIFO drain
  input wire logic i_tx_pop,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  // Receive FIFO fill
  input wire logic i_rx_push,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_full,
  // Control out
  output logic [15:0] o_master_ctrl,
  output logic o_master_clk_en,
  output logic o_irq
);

  // --------------------------------------------------------------------
  // Line monitor in the link domain
  // --------------------------------------------------------------------
  line_if lines ();

  line_monitor u_line_monitor (
    .i_link_clk (i_link_clk),
    .i_resetn (i_resetn),
    .i_scl (i_scl),
    .i_sda (i_sda),
    .lines (lines)
  );

  // --------------------------------------------------------------------
  // Crossing into the core domain
  // --------------------------------------------------------------------
  logic [1:0] scl_lvl_q;
  logic [1:0] sda_lvl_q;
  logic [2:0] start_sync_q;
  logic [2:0] stop_sync_q;
  logic start_seen;
  logic stop_seen;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_lvl_q <= 2'b11;
      sda_lvl_q <= 2'b11;
    end else begin
      scl_lvl_q <= {scl_lvl_q[0], lines.scl_filt};
      sda_lvl_q <= {sda_lvl_q[0], lines.sda_filt};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_sync_q <= 3'b000;
      stop_sync_q <= 3'b000;
    end else begin
      start_sync_q <= {start_sync_q[1:0], lines.start_tgl};
      stop_sync_q <= {stop_sync_q[1:0], lines.stop_tgl};
    end
  end

  assign start_seen = start_sync_q[2] ^ start_sync_q[1];
  assign stop_seen = stop_sync_q[2] ^ stop_sync_q[1];

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  logic hit_ctrl;
  logic hit_stat;
  logic hit_rx;
  logic hit_tx;
  logic stat_read;

  assign hit_ctrl = (i_addr == ADDR_W'(`MCON_ADDR));
  assign hit_stat = (i_addr == ADDR_W'(`MSTAT_ADDR));
  assign hit_rx = (i_addr == ADDR_W'(`MRX_ADDR));
  assign hit_tx = (i_addr == ADDR_W'(`MTX_ADDR));
  assign stat_read = i_rd && hit_stat;

  // --------------------------------------------------------------------
  // Master control register
  // --------------------------------------------------------------------
  logic [15:0] ctrl_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= `MCON_RESET;
    end else if (i_wr && hit_ctrl) begin
      ctrl_q <= i_wdata & `MCON_WMASK;
    end
  end

  logic master_en;
  logic cmp_ien;
  logic nack_ien;
  logic arb_ien;
  logic txreq_ien;
  logic rxreq_ien;

  assign master_en = ctrl_q[`MCON_MASTER_EN];
  assign cmp_ien = ctrl_q[`MCON_CMP_IEN];
  assign nack_ien = ctrl_q[`MCON_NACK_IEN];
  assign arb_ien = ctrl_q[`MCON_ARB_IEN];
  assign txreq_ien = ctrl_q[`MCON_TXREQ_IEN];
  assign rxreq_ien = ctrl_q[`MCON_RXREQ_IEN];
  assign o_master_ctrl = ctrl_q;
  assign o_master_clk_en = master_en;

  // --------------------------------------------------------------------
  // Transmit FIFO, filled by software, drained by the state machine
  // --------------------------------------------------------------------
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  byte_t tx_mem_q [FIFO_DEPTH];
  logic [PW-1:0] tx_wp_q;
  logic [PW-1:0] tx_rp_q;
  logic [CW-1:0] tx_cnt_q;
  byte_t tx_cur_q;
  logic tx_push;
  logic tx_pop;
  logic tx_full;

  assign tx_full = (tx_cnt_q == CW'(FIFO_DEPTH));
  assign tx_push = i_wr && hit_tx && !tx_full;
  assign tx_pop = i_tx_pop && (tx_cnt_q != '0);

  always_ff @(posedge i_core_clk) begin
    if (tx_push) tx_mem_q[tx_wp_q] <= i_wdata[7:0];
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) tx_wp_q <= (tx_wp_q == PW'(FIFO_DEPTH - 1)) ? '0 : tx_wp_q + 1'b1;
      if (tx_pop) tx_rp_q <= (tx_rp_q == PW'(FIFO_DEPTH - 1)) ? '0 : tx_rp_q + 1'b1;
      if (tx_push && !tx_pop) tx_cnt_q <= tx_cnt_q + 1'b1;
      else if (tx_pop && !tx_push) tx_cnt_q <= tx_cnt_q - 1'b1;
    end
  end

  // Byte now on the line, kept for read-back
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_cur_q <= `ZERO8;
    end else if (tx_pop) begin
      tx_cur_q <= tx_mem_q[tx_rp_q];
    end
  end

  assign o_tx_valid = (tx_cnt_q != '0);
  assign o_tx_data = tx_mem_q[tx_rp_q];

  // --------------------------------------------------------------------
  // Receive FIFO, filled by the state machine, drained by software
  // --------------------------------------------------------------------
  byte_t rx_mem_q [FIFO_DEPTH];
  logic [PW-1:0] rx_wp_q;
  logic [PW-1:0] rx_rp_q;
  logic [CW-1:0] rx_cnt_q;
  logic rx_push;
  logic rx_pop;
  logic rx_full;

  assign rx_full = (rx_cnt_q == CW'(FIFO_DEPTH));
  assign rx_push = i_rx_push && !rx_full;
  assign rx_pop = i_rd && hit_rx && (rx_cnt_q != '0);
  assign o_rx_full = rx_full;

  always_ff @(posedge i_core_clk) begin
    if (rx_push) rx_mem_q[rx_wp_q] <= i_rx_data;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) rx_wp_q <= (rx_wp_q == PW'(FIFO_DEPTH - 1)) ? '0 : rx_wp_q + 1'b1;
      if (rx_pop) rx_rp_q <= (rx_rp_q == PW'(FIFO_DEPTH - 1)) ? '0 : rx_rp_q + 1'b1;
      if (rx_push && !rx_pop) rx_cnt_q <= rx_cnt_q + 1'b1;
      else if (rx_pop && !rx_push) rx_cnt_q <= rx_cnt_q - 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Line busy tracking
  // --------------------------------------------------------------------
  logic line_busy_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      line_busy_q <= 1'b0;
    end else if (start_seen) begin
      line_busy_q <= 1'b1;
    end else if (stop_seen) begin
      line_busy_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Sticky flags; a set in the read cycle beats the clear
  // --------------------------------------------------------------------
  logic tx_uflow_q;
  logic own_stop_q;
  logic rx_ovf_q;
  logic transaction_complete_flag_q;
  logic data_nack_q;
  logic arb_lost_q;
  logic addr_nack_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_uflow_q <= 1'b0;
      own_stop_q <= 1'b0;
      rx_ovf_q <= 1'b0;
      transaction_complete_flag_q <= 1'b0;
    end else begin
      tx_uflow_q <= (i_tx_empty_end && txreq_ien) || (tx_uflow_q && !stat_read);
      own_stop_q <= i_own_stop || (own_stop_q && !stat_read);
      rx_ovf_q <= (i_rx_push && rx_full) || (rx_ovf_q && !stat_read);
      transaction_complete_flag_q <= (stop_seen && master_en) || (transaction_complete_flag_q && !stat_read);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      data_nack_q <= 1'b0;
      arb_lost_q <= 1'b0;
      addr_nack_q <= 1'b0;
    end else begin
      data_nack_q <= i_data_nack || (data_nack_q && !stat_read);
      arb_lost_q <= i_arb_lost || (arb_lost_q && !stat_read);
      addr_nack_q <= i_addr_nack || (addr_nack_q && !stat_read);
    end
  end

  // --------------------------------------------------------------------
  // Live status terms
  // --------------------------------------------------------------------
  logic rx_req;
  logic tx_req;
  fill_e tx_fill;
  logic [1:0] tx_fill_code;

  assign rx_req = (rx_cnt_q != '0);
  assign tx_req = !i_direction_read && !tx_full;

  always_comb begin
    if (tx_cnt_q == '0) tx_fill = FILL_EMPTY;
    else if (tx_full) tx_fill = FILL_FULL;
    else tx_fill = FILL_ONE;
  end

  always_comb begin
    case (tx_fill)
      FILL_EMPTY: tx_fill_code = `FILL_CODE_EMPTY;
      FILL_ONE: tx_fill_code = `FILL_CODE_ONE;
      FILL_FULL: tx_fill_code = `FILL_CODE_FULL;
      default: tx_fill_code = `FILL_CODE_EMPTY;
    endcase
  end

  // --------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------
  word_t status;

  always_comb begin
    status = `ZERO16;
    status[`ST_SCL] = scl_lvl_q[1];
    status[`ST_SDA] = sda_lvl_q[1];
    status[`ST_TX_UFLOW] = tx_uflow_q;
    status[`ST_OWN_STOP] = own_stop_q;
    status[`ST_LINE_BUSY] = line_busy_q;
    status[`ST_RX_OVF] = rx_ovf_q;
    status[`ST_TRANSACTION_COMPLETE_FLAG] = transaction_complete_flag_q;
    status[`ST_DATA_NACK] = data_nack_q;
    status[`ST_MASTER_BUSY] = i_machine_busy;
    status[`ST_ARB_LOST] = arb_lost_q;
    status[`ST_ADDR_NACK] = addr_nack_q;
    status[`ST_RXREQ] = rx_req;
    status[`ST_TXREQ] = tx_req;
    status[`ST_FILL_HI:`ST_FILL_LO] = tx_fill_code;
  end

  // --------------------------------------------------------------------
  // Interrupt request from enabled sources
  // --------------------------------------------------------------------
  always_comb begin
    o_irq = (transaction_complete_flag_q && cmp_ien)
      || ((data_nack_q || addr_nack_q) && nack_ien)
      || (arb_lost_q && arb_ien)
      || (rx_req && rxreq_ien)
      || (tx_req && txreq_ien);
  end

  // --------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // --------------------------------------------------------------------
  word_t rdata_q;
  word_t rdata_d;

  always_comb begin
    rdata_d = `ZERO16;
    if (hit_ctrl) rdata_d = ctrl_q;
    else if (hit_stat) rdata_d = status;
    else if (hit_rx) rdata_d = {`ZERO8, rx_mem_q[rx_rp_q]};
    else if (hit_tx) rdata_d = {`ZERO8, tx_cur_q};
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= `ZERO16;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= `ZERO16;
    end
  end

  assign o_rdata = rdata_q;

endmodule : i2c_master_status

`default_nettype wire

// ==== verification/i2c_master_status_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "i2c_status_consts.svh"

module i2c_master_status_chk #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // Machine side
  input wire logic i_machine_busy,
  input wire logic i_direction_read,
  input wire logic i_own_stop,
  input wire logic i_data_nack,
  input wire logic i_addr_nack,
  input wire logic i_arb_lost,
  input wire logic o_tx_valid,
  input wire logic i_rx_push,
  input wire logic o_rx_full,
  // Control
  input wire logic [15:0] o_master_ctrl,
  input wire logic o_master_clk_en,
  input wire logic o_irq
);
  // ------------------------------
  // Decodes
  // ------------------------------
  wire logic rs = i_rd && (i_addr == `MSTAT_ADDR);
  wire logic wc = i_wr && (i_addr == `MCON_ADDR);
  wire logic ev = i_data_nack || i_addr_nack || i_arb_lost;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  // ------------------------------
  // Properties
  // ------------------------------
  chk_busy_bit: assert property (rs |=> o_rdata[6] == $past(i_machine_busy))
    else $error("busy bit differs from machine state");
  chk_fill_empty: assert property (rs && !o_tx_valid |=> o_rdata[1:0] == 2'h0)
    else $error("fill code wrong for empty fifo");
  chk_txreq_bit: assert property (rs |=>
    o_rdata[2] == (!$past(i_direction_read) && o_rdata[1:0] != 2'h3))
    else $error("transmit request bit wrong");
  chk_rxreq_full: assert property (rs && o_rx_full |=> o_rdata[3])
    else $error("receive request low with data held");
  chk_data_nack: assert property (i_data_nack ##1 !rs ##1 rs |=> o_rdata[7])
    else $error("data nack flag missing");
  chk_addr_nack: assert property (i_addr_nack ##1 !rs ##1 rs |=> o_rdata[4])
    else $error("address nack flag missing");
  chk_own_stop: assert property (i_own_stop ##1 !rs ##1 rs |=> o_rdata[11])
    else $error("own stop flag missing");
  chk_arb_same: assert property ((rs && i_arb_lost) ##1 !rs ##1 rs |=> o_rdata[5])
    else $error("event lost in read cycle");
  chk_read_clear: assert property ((rs && !ev) ##1 !ev ##1 rs |=>
    o_rdata[7] == 1'h0 && o_rdata[5:4] == 2'h0)
    else $error("flag not cleared by read");
  chk_rx_ovf: assert property ((i_rx_push && o_rx_full) ##1 !rs ##1 rs |=> o_rdata[9])
    else $error("overflow flag missing");
  chk_ctrl_mask: assert property (wc |=> o_master_ctrl == ($past(i_wdata) & `MCON_WMASK))
    else $error("control write wrong");
  chk_clk_gate: assert property (wc |=> o_master_clk_en == $past(i_wdata[0]))
    else $error("clock enable not from control bit");
  chk_irq_off: assert property (o_master_ctrl[8:4] == 5'h00 |-> !o_irq)
    else $error("interrupt with all enables clear");

  cov_flag_read: cover property (i_arb_lost ##1 !rs ##1 rs);
  cov_rx_ovf: cover property (i_rx_push && o_rx_full);
  cov_irq: cover property (o_irq);
endmodule : i2c_master_status_chk

bind i2c_master_status i2c_master_status_chk #(.ADDR_W(ADDR_W)) chk (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_machine_busy(i_machine_busy),
  .i_direction_read(i_direction_read), .i_own_stop(i_own_stop), .i_data_nack(i_data_nack),
  .i_addr_nack(i_addr_nack), .i_arb_lost(i_arb_lost), .o_tx_valid(o_tx_valid),
  .i_rx_push(i_rx_push), .o_rx_full(o_rx_full), .o_master_ctrl(o_master_ctrl),
  .o_master_clk_en(o_master_clk_en), .o_irq(o_irq));

`default_nettype wire

// ==== verification/i2c_line_agent.sv ====
`timescale 1ns/1ns
`default_nettype none

module i2c_line_agent (
  // Bus lines after the pull-ups
  output logic o_scl,
  output logic o_sda
);
  // Released lines float high through the pull-ups
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end

  // Phases long enough to pass the sync stages and the glitch filter
  task automatic start_cond();
    o_sda = 1'h0;
    #800 o_scl = 1'h0;
    #800;
  endtask : start_cond

  task automatic stop_cond();
    o_sda = 1'h0;
    #800 o_scl = 1'h1;
    #800 o_sda = 1'h1;
    #800;
  endtask : stop_cond
endmodule : i2c_line_agent

`default_nettype wire

// ==== verification/test_i2c_master_status.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "i2c_status_consts.svh"

module test_i2c_master_status
  import i2c_status_pkg::*;
;
  // ------------------------------
  // Stimulus and observed signals
  // ------------------------------
  logic core_clk = 1'h0;
  logic link_clk = 1'h0;
  logic resetn = 1'h0;
  logic [31:0] addr = 32'h0000_0000;
  word_t wdata = 16'h0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic busy = 1'h0;
  logic dir_rd = 1'h0;
  logic [6:0] ev = 7'h00;
  byte_t rx_data = 8'h00;
  word_t rdata, ctrl, s, v, r;
  logic tx_valid, rx_full, clk_en, irq, scl, sda;
  byte_t tx_data;
  byte_t b[3];
  int pos[5] = '{4, 5, 7, 11, 12};
  int num_errors = 0;
  int cmp_count = 0;

  always #4 core_clk = ~core_clk;
  initial #5 forever #32 link_clk = ~link_clk;

  i2c_master_status DUT (
    .i_core_clk(core_clk), .i_link_clk(link_clk), .i_resetn(resetn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_scl(scl), .i_sda(sda),
    .i_machine_busy(busy), .i_direction_read(dir_rd), .i_own_stop(ev[3]),
    .i_tx_empty_end(ev[4]), .i_data_nack(ev[2]), .i_addr_nack(ev[0]),
    .i_arb_lost(ev[1]), .i_tx_pop(ev[5]), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_rx_push(ev[6]), .i_rx_data(rx_data), .o_rx_full(rx_full),
    .o_master_ctrl(ctrl), .o_master_clk_en(clk_en), .o_irq(irq));

  i2c_line_agent agent (.o_scl(scl), .o_sda(sda));

  // ------------------------------
  // Tasks and expectations
  // ------------------------------
  task automatic check(input string n, input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [31:0] a, input word_t d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge core_clk);
    wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [31:0] a, output word_t d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge core_clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic stat();
    rd_reg(`MSTAT_ADDR, s);
  endtask : stat

  task automatic pulse(input logic [6:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 7'h00;
  endtask : pulse

  function automatic logic [1:0] fill(input int n);
    return (n == 0) ? 2'h0 : (n == 1) ? 2'h2 : 2'h3;
  endfunction : fill

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    void'($urandom(95));
    repeat (2) @(posedge link_clk);
    resetn <= 1'h1;
    stat();
    check("reset status", s, 16'h6004);
    // Master stays off until a completion can be seen before clearing it
    r = 16'($urandom) & 16'hFFFE;
    wr_reg(`MCON_ADDR, r);
    rd_reg(`MCON_ADDR, v);
    check("ctrl read", v, r & `MCON_WMASK);
    check("ctrl out", ctrl, r & `MCON_WMASK);
    rd_reg(32'h4000_3440, v);
    check("unmapped", v, 16'h0000);
    wr_reg(`MCON_ADDR, 16'h0020);
    for (int n = 0; n < 4; n++) begin
      stat();
      check("tx fill", s & 16'h000F, {13'h0000, n < 2, fill(n)});
      if (n < 2) b[n] = 8'($urandom);
      wr_reg(`MTX_ADDR, {8'h00, b[n % 2]});
    end
    check("tx head", tx_data, b[0]);
    pulse(7'h20);
    stat();
    check("tx pop", {s[1:0], 6'h00, tx_data}, {2'h2, 6'h00, b[1]});
    rd_reg(`MTX_ADDR, v);
    check("tx readback", v, {8'h00, b[0]});
    pulse(7'h20);
    @(negedge core_clk);
    check("tx drained", tx_valid, 1'h0);
    for (int n = 0; n < 3; n++) begin
      b[n] = 8'($urandom);
      rx_data <= b[n];
      pulse(7'h40);
    end
    stat();
    check("rx full", {s & 16'h0208, 7'h00, rx_full}, 24'h0208_01);
    for (int n = 0; n < 2; n++) begin
      rd_reg(`MRX_ADDR, v);
      check("rx byte", v, {8'h00, b[n]});
    end
    stat();
    check("rx empty", s & 16'h0208, 16'h0000);
    dir_rd <= 1'h1;
    for (int k = 0; k < 5; k++) begin
      pulse(7'h01 << k);
      stat();
      check("flag set", s[pos[k]], 1'h1);
      stat();
      check("flag clear", s[pos[k]], 1'h0);
    end
    pulse(7'h07);
    stat();
    check("flags set", s & 16'h00B0, 16'h00B0);
    stat();
    check("one read clears", s & 16'h1BB0, 16'h0000);
    @(posedge core_clk);
    ev <= 7'h02;
    addr <= `MSTAT_ADDR;
    rd <= 1'h1;
    @(posedge core_clk);
    ev <= 7'h00;
    rd <= 1'h0;
    stat();
    check("read cycle event", s[5], 1'h1);
    wr_reg(`MCON_ADDR, 16'h0080);
    pulse(7'h10);
    stat();
    check("underflow gated", s[12], 1'h0);
    pulse(7'h04);
    @(negedge core_clk);
    check("irq raised", irq, 1'h1);
    stat();
    check("irq cleared", irq, 1'h0);
    repeat (4) begin
      busy <= 1'($urandom);
      stat();
      check("master busy", s[6], busy);
    end
    // Enable first, then disable only after completion was seen
    for (int en = 1; en >= 0; en--) begin
      wr_reg(`MCON_ADDR, 16'(en));
      agent.start_cond();
      repeat (200) @(posedge core_clk);
      stat();
      check("after start", s & 16'h6400, 16'h0400);
      agent.stop_cond();
      repeat (200) @(posedge core_clk);
      stat();
      check("after stop", s & 16'h6D00, {7'h30, en[0], 8'h00});
      check("clock gate", clk_en, en[0]);
    end
    results();
  end

  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule : test_i2c_master_status

`default_nettype wire
